// File: verif/host_port_model.sv
// Host serial port model: frames the converter and captures its serial word.
// Assumes the bench requests one frame at a time through req and n_falls.
`timescale 1ns/1ps
`default_nettype none

module host_port_model (
   input  wire logic        req,
   input  wire logic [4:0]  n_falls,
   input  wire logic        sdo,
   input  wire logic        sdo_oe,
   output logic             sclk,
   output logic             sel_n,
   output logic             done,
   output logic [14:0]      cap,
   output logic             oe16
);
   // Host spacing after select rise, 360 ns at 15 ns
   localparam int QUIET_INTERVAL_SCLKS = 24;

   logic line;
   int   i;

   // Floating line seen as high impedance (z) so a missing drive cannot match
   assign line = sdo_oe ? sdo : 1'bz;

   // Free-running serial clock, 15 ns
   initial begin
      sclk = 1'b0;
      forever #7.5 sclk = ~sclk;
   end

   initial begin
      sel_n = 1'b1;
      done  = 1'b0;
      cap   = 15'h0000;
      oe16  = 1'b0;
      forever begin
         wait (req === 1'b1);
         @(posedge sclk);
         sel_n = 1'b0;
         cap   = 15'h0000;
         oe16  = 1'bx;
         // Hold select for the requested fall count, sampling after falls 1 to 15 and the enable after fall 16
         for (i = 1; i <= n_falls; i++) begin
            @(negedge sclk);
            @(posedge sclk);
            if (i <= 15) cap = {cap[13:0], line};
            if (i == 16) oe16 = sdo_oe;
         end
         sel_n = 1'b1;
         // Quiet interval; also covers 350 ns after the 13th rise
         repeat (QUIET_INTERVAL_SCLKS) @(posedge sclk);
         done = 1'b1;
         wait (req === 1'b0);
         done = 1'b0;
      end
   end
endmodule

`default_nettype wire

// File: verif/serial_adc_frame_power_control_tb.sv
// Self-checking bench for the frame and power-mode control.
// Assumes host_port_model drives select and serial clock.
`timescale 1ns/1ps
`default_nettype none

module serial_adc_frame_power_control_tb;
   import adc_frame_pkg::*;

   logic        mclk;
   logic        rst;
   logic        link_sclk;
   logic        frame_sel_n;
   logic [7:0]  sample_code;
   logic        result_serial_out;
   logic        result_serial_oe;
   mode_t       power_mode;
   logic        analog_power_on;
   logic        sample_hold;
   logic [7:0]  result_code;
   logic        result_valid;
   logic        frame_aborted;
   logic        conversion_dummy;
   logic        req;
   logic [4:0]  nf;
   logic        done;
   logic [14:0] cap;
   logic        oe16;
   int          n_mismatch;
   int          total_checks;
   int          n_valid;
   int          n_abort;
   int          dv;
   int          da;
   logic        saw_pu;
   logic        saw_hold;

   adc_frame_ctrl dut_u (
      .mclk              (mclk),
      .rst               (rst),
      .link_sclk         (link_sclk),
      .frame_sel_n       (frame_sel_n),
      .sample_code       (sample_code),
      .result_serial_out (result_serial_out),
      .result_serial_oe  (result_serial_oe),
      .power_mode        (power_mode),
      .analog_power_on   (analog_power_on),
      .sample_hold       (sample_hold),
      .result_code       (result_code),
      .result_valid      (result_valid),
      .frame_aborted     (frame_aborted),
      .conversion_dummy  (conversion_dummy)
   );

   host_port_model host_u (
      .req     (req),
      .n_falls (nf),
      .sdo     (result_serial_out),
      .sdo_oe  (result_serial_oe),
      .sclk    (link_sclk),
      .sel_n   (frame_sel_n),
      .done    (done),
      .cap     (cap),
      .oe16    (oe16)
   );

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Pulse and mode watchers
   always @(posedge mclk) begin
      if (result_valid === 1'b1) n_valid++;
      if (frame_aborted === 1'b1) n_abort++;
      if (power_mode === MODE_POWERUP) saw_pu = 1'b1;
      if (sample_hold === 1'b1) saw_hold = 1'b1;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic final_report;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One host frame of n falls with the given analog code
   task automatic frame(input logic [4:0] n, input logic [7:0] code);
      int k;
      int v0;
      int a0;
      @(posedge mclk);
      sample_code <= code;
      repeat (20) @(posedge mclk);
      v0 = n_valid;
      a0 = n_abort;
      saw_pu = 1'b0;
      saw_hold = 1'b0;
      req <= 1'b1;
      nf <= n;
      for (k = 0; k < 400 && done !== 1'b1; k++) @(posedge mclk);
      if (done !== 1'b1) chk(16'h0dea, 16'h0d0e);
      req <= 1'b0;
      repeat (2) @(posedge mclk);
      dv = n_valid - v0;
      da = n_abort - a0;
   endtask

   task automatic t_dummy;
      frame(5'h10, 8'h3c);
      chk(16'(dv), 16'h0000);
      chk(16'(conversion_dummy), 16'h0000);
      chk(16'(result_code), 16'h003c);
      chk(16'(oe16), 16'h0000);
   endtask

   task automatic t_full;
      frame(5'h14, 8'ha5);
      chk(16'(cap), {1'b0, 2'h0, 8'ha5, 5'h00});
      chk(16'(dv), 16'h0001);
      chk(16'(result_code), 16'h00a5);
      chk(16'(saw_hold), 16'h0001);
      chk(16'(oe16), 16'h0000);
   endtask

   task automatic t_noise;
      frame(5'h01, 8'h11);
      chk(16'(power_mode), 16'(MODE_NORMAL));
      chk(16'(da), 16'h0000);
   endtask

   task automatic t_trunc;
      frame(5'h0a, 8'h96);
      chk(16'(cap[9:0]), {6'h00, 2'h0, 8'h96});
      chk(16'(power_mode), 16'(MODE_NORMAL));
      chk(16'(da), 16'h0001);
      chk(16'(dv), 16'h0000);
      chk(16'(result_serial_oe), 16'h0000);
   endtask

   task automatic t_shut;
      frame(5'h02, 8'h22);
      chk(16'(power_mode), 16'(MODE_SHUTDOWN));
      chk(16'(analog_power_on), 16'h0000);
      chk(16'(da), 16'h0001);
      repeat (60) @(posedge mclk);
      chk(16'(power_mode), 16'(MODE_SHUTDOWN));
   endtask

   task automatic t_wake_fail;
      frame(5'h09, 8'h33);
      chk(16'(saw_pu), 16'h0001);
      chk(16'(power_mode), 16'(MODE_SHUTDOWN));
   endtask

   task automatic t_wake;
      frame(5'h10, 8'h5a);
      chk(16'(power_mode), 16'(MODE_NORMAL));
      chk(16'(analog_power_on), 16'h0001);
      chk(16'(dv), 16'h0000);
      frame(5'h14, 8'hc3);
      chk(16'(dv), 16'h0001);
      chk(16'(result_code), 16'h00c3);
   endtask

   initial begin
      #40us;
      n_mismatch++;
      final_report();
   end

   initial begin
      n_mismatch = 0;
      total_checks = 0;
      n_valid = 0;
      n_abort = 0;
      rst = 1'b1;
      req = 1'b0;
      nf = 5'h00;
      sample_code = 8'h00;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      repeat (10) @(posedge mclk);
      chk(16'(power_mode), 16'(MODE_NORMAL));
      chk(16'(conversion_dummy), 16'h0001);
      t_dummy();
      t_full();
      t_noise();
      t_trunc();
      t_shut();
      t_wake_fail();
      t_wake();
      final_report();
   end
endmodule

`default_nettype wire

// File: verilog/adc_frame_ctrl.sv
// Frame, output and power-mode control of a serial sampling converter.
// Assumes the host drives frame_sel_n and link_sclk; link logic runs on
// falling link_sclk, mode logic on mclk, with synchronised crossings.
`timescale 1ns/1ps
`default_nettype none

module adc_frame_ctrl
   import adc_frame_pkg::*;
(
   input  wire logic                          mclk,
   input  wire logic                          rst,
   input  wire logic                          link_sclk,
   input  wire logic                          frame_sel_n,
   input  wire logic [adc_frame_pkg::CODE_BITS-1:0] sample_code,
   output var  logic                          result_serial_out,
   output logic                               result_serial_oe,
   output adc_frame_pkg::mode_t               power_mode,
   output var  logic                          analog_power_on,
   output var  logic                          sample_hold,
   output var  logic [adc_frame_pkg::CODE_BITS-1:0] result_code,
   output var  logic                          result_valid,
   output var  logic                          frame_aborted,
   output var  logic                          conversion_dummy
);

   import adc_frame_pkg::*;

   // Link side, on falling serial clock
   logic                 sclk_n;
   logic                 frame_idle;
   logic                 frame_new;
   logic                 frame_tog;
   logic [4:0]           fall_count;
   logic [4:0]           next_count;
   logic [4:0]           bit_sel;
   logic [1:0]           fall_class;
   logic [1:0]           next_class;
   logic                 next_bit;
   logic [CODE_BITS-1:0] word_link;
   logic [CODE_BITS-1:0] word_cap;

   // Core side, on mclk
   logic                 cs_q;
   logic                 cs_d;
   logic                 cs_fall_evt;
   logic                 frame_end;
   logic                 tog_q;
   logic                 tog_seen;
   logic [1:0]           class_q;
   logic [1:0]           end_class;
   logic [CODE_BITS-1:0] track_code;
   mode_t                mode;
   mode_t                next_mode;

   assign sclk_n     = ~link_sclk;
   assign frame_idle = rst | frame_sel_n;

   // Held word crosses into the serial clock domain
   pin_sync #(
      .WIDTH     (CODE_BITS),
      .RESET_VAL ('0)
   ) u_word_sync (
      .clk  (sclk_n),
      .rst  (rst),
      .din  (track_code),
      .dout (word_link)
   );

   always_comb begin
      if (frame_new) begin
         next_count = FALL_FIRST;
      end else if (fall_count == COUNT_SAT) begin
         next_count = COUNT_SAT;
      end else begin
         next_count = fall_count + 5'h01;
      end
   end

   always_comb begin
      if (next_count >= FALL_FULL) begin
         next_class = CLASS_FULL;
      end else if (next_count >= FALL_KEEP) begin
         next_class = CLASS_ABORT;
      end else if (next_count >= FALL_SHUT) begin
         next_class = CLASS_SHUT;
      end else begin
         next_class = CLASS_SHORT;
      end
   end

   assign bit_sel = FALL_LAST_DATA - next_count;

   always_comb begin
      if (next_count >= FALL_FIRST_DATA && next_count <= FALL_LAST_DATA) begin
         next_bit = word_cap[bit_sel[2:0]];
      end else begin
         next_bit = 1'b0;
      end
   end

   // Set while select is high; cleared by the first fall of a frame
   always_ff @(negedge link_sclk or posedge frame_idle) begin
      if (frame_idle) begin
         frame_new <= 1'b1;
      end else begin
         frame_new <= 1'b0;
      end
   end

   always_ff @(negedge link_sclk or posedge rst) begin
      if (rst) begin
         fall_count <= 5'h00;
         fall_class <= CLASS_SHORT;
         frame_tog  <= 1'b0;
      end else if (!frame_sel_n) begin
         fall_count <= next_count;
         fall_class <= next_class;
         if (frame_new) begin
            frame_tog <= ~frame_tog;
         end
      end
   end

   always_ff @(negedge link_sclk or posedge rst) begin
      if (rst) begin
         word_cap <= '0;
      end else if (!frame_sel_n && next_count == FALL_LATCH) begin
         word_cap <= word_link;
      end
   end

   // Zero from the select fall; bits advance on each fall
   always_ff @(negedge link_sclk or posedge frame_idle) begin
      if (frame_idle) begin
         result_serial_out <= 1'b0;
      end else begin
         result_serial_out <= next_bit;
      end
   end

   // Driven from select fall until the sixteenth fall or select rise
   assign result_serial_oe = !frame_sel_n && (frame_new || fall_count < FALL_FULL);

   // Core side crossings
   pin_sync #(
      .WIDTH     (1),
      .RESET_VAL (RESET_PIN_N)
   ) u_cs_sync (
      .clk  (mclk),
      .rst  (rst),
      .din  (frame_sel_n),
      .dout (cs_q)
   );

   pin_sync #(
      .WIDTH     (3),
      .RESET_VAL (3'h0)
   ) u_link_sync (
      .clk  (mclk),
      .rst  (rst),
      .din  ({frame_tog, fall_class}),
      .dout ({tog_q, class_q})
   );

   assign cs_fall_evt = cs_d & ~cs_q;
   assign frame_end   = ~cs_d & cs_q;
   // A frame with no fall leaves the toggle unchanged
   assign end_class   = (tog_q != tog_seen) ? class_q : CLASS_SHORT;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cs_d     <= RESET_PIN_N;
         tog_seen <= 1'b0;
      end else begin
         cs_d <= cs_q;
         if (frame_end) begin
            tog_seen <= tog_q;
         end
      end
   end

   always_comb begin
      next_mode = mode;
      if (cs_fall_evt && mode == MODE_SHUTDOWN) begin
         next_mode = MODE_POWERUP;
      end else if (frame_end) begin
         case (mode)
            MODE_NORMAL: begin
               if (end_class == CLASS_SHUT) begin
                  next_mode = MODE_SHUTDOWN;
               end else begin
                  next_mode = MODE_NORMAL;
               end
            end
            MODE_POWERUP: begin
               if (end_class == CLASS_SHORT || end_class == CLASS_SHUT) begin
                  next_mode = MODE_SHUTDOWN;
               end else begin
                  next_mode = MODE_NORMAL;
               end
            end
            default: begin
               next_mode = mode;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode            <= RESET_MODE;
         analog_power_on <= (RESET_MODE != MODE_SHUTDOWN);
      end else begin
         mode            <= next_mode;
         analog_power_on <= (next_mode != MODE_SHUTDOWN);
      end
   end

   assign power_mode = mode;

   // Track while select is high, hold through the frame
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         track_code  <= '0;
         sample_hold <= 1'b0;
      end else begin
         if (cs_q) begin
            track_code <= sample_code;
         end
         if (cs_fall_evt) begin
            sample_hold <= 1'b1;
         end else if (frame_end) begin
            sample_hold <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         conversion_dummy <= RESET_DUMMY;
      end else if (cs_fall_evt && mode == MODE_SHUTDOWN) begin
         conversion_dummy <= 1'b1;
      end else if (frame_end && end_class == CLASS_FULL) begin
         conversion_dummy <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         result_valid  <= 1'b0;
         frame_aborted <= 1'b0;
         result_code   <= '0;
      end else begin
         result_valid  <= frame_end && mode == MODE_NORMAL && end_class == CLASS_FULL && !conversion_dummy;
         frame_aborted <= frame_end && mode != MODE_SHUTDOWN &&
                          (end_class == CLASS_SHUT || end_class == CLASS_ABORT);
         if (frame_end && end_class == CLASS_FULL) begin
            result_code <= track_code;
         end
      end
   end

   property p_wake;
      @(posedge mclk) disable iff (rst)
      (cs_fall_evt && mode == MODE_SHUTDOWN) |=> (mode == MODE_POWERUP && conversion_dummy);
   endproperty
   a_wake: assert property (p_wake) else $error("shutdown not left on select fall");

   property p_shut_entry;
      @(posedge mclk) disable iff (rst)
      (frame_end && mode == MODE_NORMAL && end_class == CLASS_SHUT) |=>
         (mode == MODE_SHUTDOWN && frame_aborted && !analog_power_on);
   endproperty
   a_shut_entry: assert property (p_shut_entry) else $error("short frame did not shut down");

   property p_short_keeps;
      @(posedge mclk) disable iff (rst)
      (frame_end && mode == MODE_NORMAL && end_class == CLASS_SHORT) |=> $stable(mode) && !frame_aborted;
   endproperty
   a_short_keeps: assert property (p_short_keeps) else $error("tiny frame changed mode");

   property p_abort_normal;
      @(posedge mclk) disable iff (rst)
      (frame_end && mode == MODE_NORMAL && end_class == CLASS_ABORT) |=>
         (mode == MODE_NORMAL && frame_aborted && !result_valid);
   endproperty
   a_abort_normal: assert property (p_abort_normal) else $error("truncated frame mishandled");

   property p_wake_fallback;
      @(posedge mclk) disable iff (rst)
      (frame_end && mode == MODE_POWERUP && end_class != CLASS_ABORT && end_class != CLASS_FULL) |=>
         mode == MODE_SHUTDOWN;
   endproperty
   a_wake_fallback: assert property (p_wake_fallback) else $error("early wake release kept power");

   property p_wake_done;
      @(posedge mclk) disable iff (rst)
      (frame_end && mode == MODE_POWERUP && end_class == CLASS_FULL) |=>
         (mode == MODE_NORMAL && !result_valid) ##1 !conversion_dummy;
   endproperty
   a_wake_done: assert property (p_wake_done) else $error("wake frame did not reach normal");

   property p_shutdown_holds;
      @(posedge mclk) disable iff (rst)
      (mode == MODE_SHUTDOWN && !cs_fall_evt) |=> mode == MODE_SHUTDOWN;
   endproperty
   a_shutdown_holds: assert property (p_shutdown_holds) else $error("shutdown left without select fall");

   property p_hold_on_fall;
      @(posedge mclk) disable iff (rst)
      cs_fall_evt |=> sample_hold && $stable(track_code);
   endproperty
   a_hold_on_fall: assert property (p_hold_on_fall) else $error("sample not held at select fall");

   property p_float_after_full;
      @(negedge link_sclk) disable iff (rst)
      (!frame_sel_n && next_count == FALL_FULL) |=> (frame_new || !result_serial_oe);
   endproperty
   a_float_after_full: assert property (p_float_after_full) else $error("output driven after full word");

   property p_lead_zero;
      @(negedge link_sclk) disable iff (rst)
      (!frame_sel_n && next_count < FALL_FIRST_DATA) |=> (frame_sel_n || !result_serial_out);
   endproperty
   a_lead_zero: assert property (p_lead_zero) else $error("leading bit not zero");

   property p_msb_first;
      @(negedge link_sclk) disable iff (rst)
      (!frame_sel_n && !frame_new && next_count == FALL_FIRST_DATA) |=>
         (frame_sel_n || result_serial_out == word_cap[CODE_BITS-1]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first data bit not the msb");

endmodule

`default_nettype wire

// File: verilog/adc_frame_pkg.sv
// Shared constants and types for the serial converter frame and power control.
// Assumes one frame select pin and one serial clock from the host, plus a core clock mclk.
//
// Contract
// - Frame select fall starts a normal-mode frame
// - Release between falls 2 and 10 shuts down
// - Release before fall 2 keeps mode
// - Release between falls 10 and 16 aborts, normal
// - Output floats after sixteen serial clock cycles
// - Shutdown holds until frame select falls
// - Wake frame result unusable, next valid; code keeps the next invalid too if the wake ends between falls 10 and 16
// - Wake frame released before fall 10 reverts
// - Wake frame past fall 10 ends normal
// - Select fall holds sample, drives output
// - Three zeros, eight bits MSB first, zeros

package adc_frame_pkg;

   localparam int         CODE_BITS       = 8;
   localparam logic [4:0] COUNT_SAT       = 5'h11;
   localparam logic [4:0] FALL_FIRST      = 5'h01;
   localparam logic [4:0] FALL_LATCH      = 5'h02;
   localparam logic [4:0] FALL_SHUT       = 5'h02;
   localparam logic [4:0] FALL_FIRST_DATA = 5'h03;
   localparam logic [4:0] FALL_LAST_DATA  = 5'h0a;
   localparam logic [4:0] FALL_KEEP       = 5'h0a;
   localparam logic [4:0] FALL_FULL       = 5'h10;

   // Frame length class, gray coded so it moves one bit per step within a frame
   localparam logic [1:0] CLASS_SHORT = 2'h0;
   localparam logic [1:0] CLASS_SHUT  = 2'h1;
   localparam logic [1:0] CLASS_ABORT = 2'h3;
   localparam logic [1:0] CLASS_FULL  = 2'h2;

   typedef enum logic [2:0] {
      MODE_NORMAL   = 3'h1,
      MODE_SHUTDOWN = 3'h2,
      MODE_POWERUP  = 3'h4
   } mode_t;

   localparam mode_t RESET_MODE  = MODE_NORMAL;
   localparam logic  RESET_DUMMY = 1'b1;
   localparam logic  RESET_PIN_N = 1'b1;

endpackage

// File: verilog/pin_sync.sv
// Three-stage synchroniser; a bit changes once stages two and three agree.
// Assumes din is asynchronous to clk; reset is asynchronous, active high.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output var  logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
         stage3 <= RESET_VAL;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               dout[i] <= RESET_VAL[i];
            end else if (stage2[i] == stage3[i]) begin
               dout[i] <= stage3[i];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire
